// File: rtl/clk_gating_pkg.sv
/*
 Constants for the peripheral clock-enable block: register offsets, enable
 bit positions, implemented-bit masks and reset values.
 Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package clk_gating_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] FAST_EN_OFF = 8'h18;
   localparam logic [7:0] SLOW_EN_OFF = 8'h1C;
   localparam logic [31:0] FAST_EN_RST = 32'h00000000;
   localparam logic [31:0] SLOW_EN_RST = 32'h00000000;
   localparam logic [31:0] RDATA_RST = 32'h00000000;

   // ----------------------------------------------------------------
   // Fast-bus enable bit positions
   // ----------------------------------------------------------------
   localparam int ALTFUNC_IO_CLK_EN = 0;
   localparam int PORT_A_CLK_EN = 2;
   localparam int PORT_G_CLK_EN = 8;
   localparam int CONVERTER_ONE_CLK_EN = 9;
   localparam int CONVERTER_TWO_CLK_EN = 10;
   localparam int ADVANCED_TIMER_A_CLK_EN = 11;
   localparam int SERIAL_PERIPH_ONE_CLK_EN = 12;
   localparam int ADVANCED_TIMER_B_CLK_EN = 13;
   localparam int SERIAL_PORT_ONE_CLK_EN = 14;
   localparam int CONVERTER_THREE_CLK_EN = 15;

   // ----------------------------------------------------------------
   // Slow-bus enable bit positions
   // ----------------------------------------------------------------
   localparam int GENERAL_TIMER_TWO_CLK_EN = 0;
   localparam int BASIC_TIMER_SEVEN_CLK_EN = 5;
   localparam int WINDOW_WATCHDOG_CLK_EN = 11;
   localparam int SERIAL_PERIPH_TWO_CLK_EN = 14;
   localparam int SERIAL_PERIPH_THREE_CLK_EN = 15;
   localparam int SERIAL_PORT_TWO_CLK_EN = 17;
   localparam int ASYNC_PORT_FIVE_CLK_EN = 20;
   localparam int TWO_WIRE_ONE_THREE_CLK_EN = 21;
   localparam int TWO_WIRE_TWO_FOUR_CLK_EN = 22;
   localparam int USB_DEVICE_CLK_EN = 23;
   localparam int FIELDBUS_ONE_CLK_EN = 25;
   localparam int FIELDBUS_TWO_CLK_EN = 26;
   localparam int BACKUP_IFACE_CLK_EN = 27;
   localparam int POWER_IFACE_CLK_EN = 28;
   localparam int DAC_IFACE_CLK_EN = 29;

   // ----------------------------------------------------------------
   // Implemented bits and gated clock counts
   // ----------------------------------------------------------------
   localparam logic [31:0] FAST_IMPL_MASK = 32'h0000FFFD;
   localparam logic [31:0] SLOW_IMPL_MASK = 32'h3EFEC83F;
   localparam int FAST_CLKS = 16;
   localparam int SLOW_CLKS = 30;

endpackage

// File: rtl/periph_read_if.sv
/*
 Carrier between the register block and a read-gating stage: enable word,
 peripheral read return coming in, gated read return going out.
 Assumes all signals sit in the clk_i domain.
*/
interface periph_read_if;
   logic [31:0] en;
   logic valid;
   logic [4:0] idx;
   logic [31:0] data;
   logic valid_q;
   logic [31:0] data_q;

   modport gate (input en, input valid, input idx, input data,
                 output valid_q, output data_q);
   modport owner (output en, output valid, output idx, output data,
                  input valid_q, input data_q);
endinterface

// File: rtl/clk_gate_cell.sv
/*
 Glitch-free clock gate for one peripheral clock.
 Assumes en_i changes only just after a rising edge of clk_i.
*/
module clk_gate_cell (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   output logic gclk_o
);

   typedef struct packed {
      logic en_lo;
   } gate_s;

   gate_s cur_ff;
   gate_s nxt_gate;

   // Enable is sampled at the falling edge of the clock
   always_comb begin
      nxt_gate = cur_ff;
      nxt_gate.en_lo = rst_i ? 1'b0 : en_i;
   end

   // Falling-edge capture keeps the enable still through the high phase
   always_ff @(negedge clk_i) begin
      cur_ff <= nxt_gate;
   end

   // No shortened pulse: the AND input only moves while clk_i is low
   assign gclk_o = clk_i & cur_ff.en_lo;

   default clocking gcb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   gate_follows_en_a: assert property (cur_ff.en_lo == en_i)
      else $error("clock gate enable not aligned to low phase");

endmodule

// File: rtl/read_zero_gate.sv
/*
 Read-return stage for one peripheral bus: passes a peripheral's read data
 only while that peripheral's clock enable bit is set, else returns zero.
 Assumes idx names the enable bit of the peripheral being read.
*/
module read_zero_gate (
   input wire logic clk_i,
   input wire logic rst_i,
   periph_read_if.gate bus
);

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } rd_s;

   rd_s cur_ff;
   rd_s nxt_rd;

   // Disabled peripherals read as zero
   always_comb begin
      nxt_rd = cur_ff;
      nxt_rd.valid = bus.valid;
      nxt_rd.data = (bus.valid && bus.en[bus.idx]) ? bus.data : '0;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_rd;
      end
   end

   assign bus.valid_q = cur_ff.valid;
   assign bus.data_q = cur_ff.data;

   default clocking rcb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   read_gated_zero_a: assert property (bus.valid && !bus.en[bus.idx]
      |=> bus.valid_q && bus.data_q == 32'h00000000)
      else $error("disabled peripheral read returned data");

   read_passes_data_a: assert property (bus.valid && bus.en[bus.idx]
      |=> bus.valid_q && bus.data_q == $past(bus.data))
      else $error("enabled peripheral read data lost");

endmodule

// File: rtl/apb_peripheral_clock_gating.sv
/*
 Peripheral clock-enable registers for the fast and slow peripheral buses,
 reached over a classic Wishbone slave, with glitch-free gated clocks and
 zero-forcing of reads from disabled peripherals.
 Assumes the busy inputs and read returns come from logic on clk_i.
*/
module apb_peripheral_clock_gating (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic fast_busy_i,
   input wire logic slow_busy_i,
   input wire logic fast_rd_valid_i,
   input wire logic [4:0] fast_rd_idx_i,
   input wire logic [31:0] fast_rd_data_i,
   output logic fast_rd_valid_o,
   output logic [31:0] fast_rd_data_o,
   input wire logic slow_rd_valid_i,
   input wire logic [4:0] slow_rd_idx_i,
   input wire logic [31:0] slow_rd_data_i,
   output logic slow_rd_valid_o,
   output logic [31:0] slow_rd_data_o,
   output logic [clk_gating_pkg::FAST_CLKS-1:0] fast_gclk_o,
   output logic [clk_gating_pkg::SLOW_CLKS-1:0] slow_gclk_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] fast_en;
      logic [31:0] slow_en;
      logic ack;
      logic [31:0] rdat;
   } regs_s;

   regs_s cur_ff;
   regs_s nxt_regs;

   logic req;
   logic hit_fast;
   logic hit_slow;
   logic stall;
   logic go;
   logic [31:0] lane_mask;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // A request is new until the ack has been given for it
   assign req = wb_cyc_i & wb_stb_i & ~cur_ff.ack;
   assign hit_fast = ({wb_adr_i[7:2], 2'b00} == clk_gating_pkg::FAST_EN_OFF);
   assign hit_slow = ({wb_adr_i[7:2], 2'b00} == clk_gating_pkg::SLOW_EN_OFF);

   // Hold off the register access while its bus has a peripheral access open
   assign stall = (hit_fast & fast_busy_i)
                | (hit_slow & slow_busy_i);
   assign go = req & ~stall;

   // Byte enables expanded to a bit mask
   always_comb begin
      lane_mask = '0;
      for (int b = 0; b < 4; b++) begin
         lane_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   end

   // ----------------------------------------------------------------
   // Register update
   // ----------------------------------------------------------------
   // Writes merge selected lanes; reads capture the addressed register
   always_comb begin
      nxt_regs = cur_ff;
      nxt_regs.ack = go;
      nxt_regs.rdat = clk_gating_pkg::RDATA_RST;
      if (go && wb_we_i && hit_fast) begin
         nxt_regs.fast_en = ((cur_ff.fast_en & ~lane_mask)
                           | (wb_dat_i & lane_mask))
                           & clk_gating_pkg::FAST_IMPL_MASK;
      end
      if (go && wb_we_i && hit_slow) begin
         nxt_regs.slow_en = ((cur_ff.slow_en & ~lane_mask)
                           | (wb_dat_i & lane_mask))
                           & clk_gating_pkg::SLOW_IMPL_MASK;
      end
      if (go && !wb_we_i) begin
         if (hit_fast) begin
            nxt_regs.rdat = cur_ff.fast_en;
         end else if (hit_slow) begin
            nxt_regs.rdat = cur_ff.slow_en;
         end
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ff.fast_en <= clk_gating_pkg::FAST_EN_RST;
         cur_ff.slow_en <= clk_gating_pkg::SLOW_EN_RST;
         cur_ff.ack <= 1'b0;
         cur_ff.rdat <= clk_gating_pkg::RDATA_RST;
      end else begin
         cur_ff <= nxt_regs;
      end
   end

   assign wb_ack_o = cur_ff.ack;
   assign wb_dat_o = cur_ff.rdat;

   // ----------------------------------------------------------------
   // Gated peripheral clocks
   // ----------------------------------------------------------------
   // One gate per implemented fast-bus bit; reserved positions stay low
   genvar gf;
   generate
      for (gf = 0; gf < clk_gating_pkg::FAST_CLKS; gf++) begin : g_fast
         if (clk_gating_pkg::FAST_IMPL_MASK[gf]) begin : g_on
            clk_gate_cell u_gate (
               .clk_i(clk_i),
               .rst_i(rst_i),
               .en_i(cur_ff.fast_en[gf]),
               .gclk_o(fast_gclk_o[gf])
            );
         end else begin : g_off
            assign fast_gclk_o[gf] = 1'b0;
         end
      end
   endgenerate

   // One gate per implemented slow-bus bit; reserved positions stay low
   genvar gs;
   generate
      for (gs = 0; gs < clk_gating_pkg::SLOW_CLKS; gs++) begin : g_slow
         if (clk_gating_pkg::SLOW_IMPL_MASK[gs]) begin : g_on
            clk_gate_cell u_gate (
               .clk_i(clk_i),
               .rst_i(rst_i),
               .en_i(cur_ff.slow_en[gs]),
               .gclk_o(slow_gclk_o[gs])
            );
         end else begin : g_off
            assign slow_gclk_o[gs] = 1'b0;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read gating of peripheral returns
   // ----------------------------------------------------------------
   periph_read_if fast_rd ();
   periph_read_if slow_rd ();

   // Fast-bus peripheral reads checked against fast enables
   assign fast_rd.en = cur_ff.fast_en;
   assign fast_rd.valid = fast_rd_valid_i;
   assign fast_rd.idx = fast_rd_idx_i;
   assign fast_rd.data = fast_rd_data_i;
   assign fast_rd_valid_o = fast_rd.valid_q;
   assign fast_rd_data_o = fast_rd.data_q;

   // Slow-bus peripheral reads checked against slow enables
   assign slow_rd.en = cur_ff.slow_en;
   assign slow_rd.valid = slow_rd_valid_i;
   assign slow_rd.idx = slow_rd_idx_i;
   assign slow_rd.data = slow_rd_data_i;
   assign slow_rd_valid_o = slow_rd.valid_q;
   assign slow_rd_data_o = slow_rd.data_q;

   read_zero_gate u_fast_rd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(fast_rd.gate)
   );

   read_zero_gate u_slow_rd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(slow_rd.gate)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Request shapes
   sequence fast_wr_s;
      req && wb_we_i && hit_fast && !fast_busy_i;
   endsequence

   sequence slow_wr_s;
      req && wb_we_i && hit_slow && !slow_busy_i;
   endsequence

   sequence fast_rd_s;
      req && !wb_we_i && hit_fast && !fast_busy_i;
   endsequence

   sequence ack_pulse_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   fast_wait_a: assert property (req && hit_fast && fast_busy_i |=> !wb_ack_o)
      else $error("fast register acked during fast-bus access");

   slow_wait_a: assert property (req && hit_slow && slow_busy_i |=> !wb_ack_o)
      else $error("slow register acked during slow-bus access");

   ack_one_cycle_a: assert property (go |=> ack_pulse_s)
      else $error("ack not a single cycle after request");

   fast_word_write_a: assert property (fast_wr_s ##0 (wb_sel_i == 4'hF)
      |=> cur_ff.fast_en == ($past(wb_dat_i) & clk_gating_pkg::FAST_IMPL_MASK))
      else $error("fast enable word write mismatch");

   slow_word_write_a: assert property (slow_wr_s ##0 (wb_sel_i == 4'hF)
      |=> cur_ff.slow_en == ($past(wb_dat_i) & clk_gating_pkg::SLOW_IMPL_MASK))
      else $error("slow enable word write mismatch");

   byte_lane_keep_a: assert property (fast_wr_s ##0 (wb_sel_i == 4'h1)
      |=> cur_ff.fast_en[31:8] == $past(cur_ff.fast_en[31:8]))
      else $error("byte write disturbed other lanes");

   fast_read_back_a: assert property (fast_rd_s |=> wb_ack_o
      && wb_dat_o == cur_ff.fast_en)
      else $error("fast register read data wrong");

   reserved_zero_a: assert property (
      ((cur_ff.fast_en & ~clk_gating_pkg::FAST_IMPL_MASK) == 32'h00000000)
      && ((cur_ff.slow_en & ~clk_gating_pkg::SLOW_IMPL_MASK) == 32'h00000000))
      else $error("reserved enable bit set");

   unmapped_zero_a: assert property (req && !wb_we_i && !hit_fast && !hit_slow
      |=> wb_ack_o && wb_dat_o == 32'h00000000)
      else $error("unmapped read not answered with zero");

   // Slow register read shape
   sequence slow_rd_s;
      req && !wb_we_i && hit_slow && !slow_busy_i;
   endsequence

   slow_read_back_a: assert property (slow_rd_s |=> wb_ack_o
      && wb_dat_o == cur_ff.slow_en)
      else $error("slow register read data wrong");

   // Partial writes leave unselected lanes alone
   half_lane_keep_a: assert property (slow_wr_s ##0 (wb_sel_i == 4'h3)
      |=> cur_ff.slow_en[31:16] == $past(cur_ff.slow_en[31:16]))
      else $error("half-word write disturbed upper lanes");

   no_lane_keep_a: assert property (fast_wr_s ##0 (wb_sel_i == 4'h0)
      |=> cur_ff.fast_en == $past(cur_ff.fast_en))
      else $error("write with no lanes changed the register");

   unmapped_write_keep_a: assert property (req && wb_we_i && !hit_fast && !hit_slow
      |=> cur_ff.fast_en == $past(cur_ff.fast_en)
      && cur_ff.slow_en == $past(cur_ff.slow_en))
      else $error("unmapped write changed an enable register");

   // Read data only stands with ack; ack only answers a request
   idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data shown without ack");

   ack_needs_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack given without a request");

   // High phase of each gated clock shows the enable caught at the last falling edge
   fast_gclk_high_a: assert property (@(negedge clk_i)
      disable iff (rst_i)
      fast_gclk_o == $past(cur_ff.fast_en[clk_gating_pkg::FAST_CLKS-1:0]))
      else $error("fast gated clock does not follow its enable");

   slow_gclk_high_a: assert property (@(negedge clk_i)
      disable iff (rst_i)
      slow_gclk_o == $past(cur_ff.slow_en[clk_gating_pkg::SLOW_CLKS-1:0]))
      else $error("slow gated clock does not follow its enable");

endmodule

// File: verification/periph_side_model.sv
/*
 Behavioural peripheral on one gated bus: a started access keeps busy high
 for a set number of cycles, then hands back one read return.
 Assumes start_i is a one-cycle pulse on clk_i with len_i of at least one.
*/
module periph_side_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [3:0] len_i,
   input wire logic [4:0] idx_i,
   input wire logic [31:0] data_i,
   output logic busy_o,
   output logic rd_valid_o,
   output logic [4:0] rd_idx_o,
   output logic [31:0] rd_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] left;
   logic [31:0] held;
   // Busy spans the access; idle return lines keep changing
   always @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_idx_o <= 5'h00;
         rd_data_o <= 32'h00000000;
         left <= 4'h0;
      end else begin
         rd_valid_o <= 1'b0;
         rd_data_o <= ~rd_data_o;
         rd_idx_o <= rd_idx_o + 5'h01;
         if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            left <= len_i;
            held <= data_i;
         end else if (busy_o) begin
            left <= left - 4'h1;
            if (left == 4'h1) begin
               busy_o <= 1'b0;
               rd_valid_o <= 1'b1;
               rd_idx_o <= idx_i;
               rd_data_o <= held;
            end
         end
      end
   end
endmodule

// File: verification/apb_peripheral_clock_gating_test.sv
/*
 Self-checking bench for the peripheral clock-enable block.
 Assumes a Wishbone master here and a peripheral model on each bus side.
*/
module apb_peripheral_clock_gating_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc, stb, we, wb_ack_o, fbusy, sbusy, fv, sv, fvo, svo;
   logic fst, sst, mon_on;
   logic [7:0] adr;
   logic [3:0] sel, flen, slen;
   logic [4:0] fi, si, fidx, sidx;
   logic [31:0] wdat, wb_dat_o, fd, sd, fdat, sdat, fdo, sdo, seed, exp_fast, exp_slow;
   logic [31:0] fexp, sexp;
   logic fexp_v, sexp_v;
   logic [15:0] fast_gclk_o;
   logic [29:0] slow_gclk_o;
   logic [7:0] adrs [3] = '{8'h18, 8'h1C, 8'h20};
   int n_errors, checks_done;

   apb_peripheral_clock_gating DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fast_busy_i(fbusy), .slow_busy_i(sbusy),
      .fast_rd_valid_i(fv), .fast_rd_idx_i(fidx), .fast_rd_data_i(fdat),
      .fast_rd_valid_o(fvo), .fast_rd_data_o(fdo), .slow_rd_valid_i(sv),
      .slow_rd_idx_i(sidx), .slow_rd_data_i(sdat), .slow_rd_valid_o(svo),
      .slow_rd_data_o(sdo), .fast_gclk_o(fast_gclk_o), .slow_gclk_o(slow_gclk_o));
   periph_side_model fast_side (.clk_i(clk_i), .rst_i(rst_i), .start_i(fst), .len_i(flen),
      .idx_i(fi), .data_i(fd), .busy_o(fbusy), .rd_valid_o(fv), .rd_idx_o(fidx),
      .rd_data_o(fdat));
   periph_side_model slow_side (.clk_i(clk_i), .rst_i(rst_i), .start_i(sst), .len_i(slen),
      .idx_i(si), .data_i(sd), .busy_o(sbusy), .rd_valid_o(sv), .rd_idx_o(sidx),
      .rd_data_o(sdat));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] old, d, input logic [3:0] s,
                                         input logic [31:0] m);
      for (int b = 0; b < 4; b++) if (s[b]) old[8*b +: 8] = d[8*b +: 8];
      return old & m;
   endfunction
   function automatic logic [31:0] expect_of(input logic [7:0] a);
      return (a == 8'h18) ? exp_fast : (a == 8'h1C) ? exp_slow : 32'h00000000;
   endfunction
   task automatic test_done();
      if (n_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmp_word(input string what, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_bit(input string what, input logic e, g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask
   // One classic cycle; n counts edges up to the one that sees ack
   task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                          input logic [31:0] d, output logic [31:0] rd, output int n);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         n_errors++;
         test_done();
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      logic [31:0] r;
      int n;
      wb_xfer(1'b1, a, s, d, r, n);
      if (a == 8'h18) exp_fast = merge(exp_fast, d, s, 32'h0000FFFD);
      if (a == 8'h1C) exp_slow = merge(exp_slow, d, s, 32'h3EFEC83F);
   endtask
   task automatic reg_check(input logic [7:0] a);
      logic [31:0] r;
      int n;
      wb_xfer(1'b0, a, 4'hF, 32'h00000000, r, n);
      cmp_word("wb_dat_o", expect_of(a), r);
   endtask
   // High phase shows the enabled clocks, low phase shows none
   task automatic check_clk();
      repeat (2) @(posedge clk_i);
      #5;
      cmp_word("fast_gclk_o", exp_fast, {16'h0000, fast_gclk_o});
      cmp_word("slow_gclk_o", exp_slow, {2'b00, slow_gclk_o});
      #12;
      cmp_word("fast_gclk_o", 32'h00000000, {16'h0000, fast_gclk_o});
      cmp_word("slow_gclk_o", 32'h00000000, {2'b00, slow_gclk_o});
   endtask
   task automatic kick(input logic [1:0] which, input logic [3:0] len);
      logic [31:0] r;
      r = rnd();
      @(posedge clk_i);
      fst <= which[0];
      sst <= which[1];
      flen <= len;
      slen <= len;
      fi <= r[4:0];
      si <= r[9:5];
      fd <= rnd();
      sd <= r;
      @(posedge clk_i);
      fst <= 1'b0;
      sst <= 1'b0;
   endtask
   task automatic wait_idle();
      int n;
      for (n = 0; n < 40 && (fbusy !== 1'b0 || sbusy !== 1'b0); n++) @(posedge clk_i);
      if (fbusy !== 1'b0 || sbusy !== 1'b0) begin
         n_errors++;
         test_done();
      end
      repeat (2) @(posedge clk_i);
   endtask

   // ----------------------------------------------------------------
   // Clock, read-return monitor and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Each return comes out one cycle later, zeroed while its clock is off
   always @(posedge clk_i) begin
      if (mon_on) begin
         cmp_bit("fast_rd_valid_o", fexp_v, fvo);
         cmp_word("fast_rd_data_o", fexp, fdo);
         cmp_bit("slow_rd_valid_o", sexp_v, svo);
         cmp_word("slow_rd_data_o", sexp, sdo);
      end
      fexp_v = fv;
      sexp_v = sv;
      fexp = (fv && exp_fast[fidx]) ? fdat : 32'h00000000;
      sexp = (sv && exp_slow[sidx]) ? sdat : 32'h00000000;
   end
   initial begin
      logic [31:0] r, rd;
      int n;
      {cyc, stb, we, fst, sst, mon_on} = '0;
      {adr, sel, wdat, flen, slen, fi, si, fd, sd} = '0;
      {exp_fast, exp_slow, n_errors, checks_done} = '0;
      seed = 32'h0000063F;
      rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      mon_on = 1'b1;
      for (int a = 0; a < 3; a++) reg_check(adrs[a]);
      for (int a = 0; a < 3; a++) reg_write(adrs[a], 4'hF, 32'hFFFFFFFF);
      for (int a = 0; a < 3; a++) reg_check(adrs[a]);
      check_clk();
      for (int a = 0; a < 3; a++) reg_write(adrs[a], 4'h0, 32'h00000000);
      for (int a = 0; a < 3; a++) reg_check(adrs[a]);
      for (int i = 0; i < 30; i++) begin
         r = rnd();
         reg_write(adrs[r[9:8] % 3], r[3:0], rnd());
         reg_check(adrs[r[9:8] % 3]);
         check_clk();
      end
      for (int k = 0; k < 2; k++) begin
         kick(k ? 2'b10 : 2'b01, 4'hC);
         wb_xfer(1'b0, k ? 8'h18 : 8'h1C, 4'hF, 32'h00000000, rd, n);
         cmp_bit("zero_wait", 1'b1, n == 2);
         wb_xfer(1'b0, k ? 8'h1C : 8'h18, 4'hF, 32'h00000000, rd, n);
         cmp_bit("stalled", 1'b1, n > 2);
         cmp_word("wb_dat_o", k ? exp_slow : exp_fast, rd);
         wait_idle();
      end
      for (int i = 0; i < 20; i++) begin
         r = rnd();
         if (i % 4 == 0) reg_write(r[0] ? 8'h18 : 8'h1C, r[7:4], rnd());
         kick(2'b11, {1'b0, r[10:8]} + 4'h1);
         wait_idle();
      end
      repeat (3) @(posedge clk_i);
      test_done();
   end
endmodule
